// >>> bench/event_status_props.sv
// Purpose: Assertions on the master event status port
// Assumes: Bound to master_event_status, one clock domain
// Notes:   Flags are observed through pending_flags
`timescale 1ns/1ns
`default_nettype none
`include "event_status_regs.vh"
module event_status_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Target port
    input wire logic        tgt_access,
    input wire logic        tgt_read,
    input wire logic [11:0] tgt_addr,
    input wire logic [3:0]  byte_enable_lanes_n,
    input wire logic [31:0] tgt_rdata,
    input wire logic        tgt_rvalid,
    // Interrupt
    input wire logic [15:0] interrupt_enable,
    input wire logic        host_interrupt_out,
    input wire logic        host_interrupt_oe,
    input wire logic [15:0] pending_flags,
    // Event sources
    input wire logic        rx_frame_end,
    input wire logic        rx_fcs_ok,
    input wire logic        rx_fifo_write,
    input wire logic        rx_fifo_full,
    input wire logic        tx_fifo_read,
    input wire logic        tx_fifo_empty
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire take = tgt_access && tgt_read && tgt_addr == `MASTER_EVENT_STATUS_OFFSET && byte_enable_lanes_n != 4'hf;
    wire under = tx_fifo_read && tx_fifo_empty;
    AST_ANSWER: assert property (take |=> tgt_rvalid) else $error("read not answered");
    AST_NONE: assert property (tgt_access && byte_enable_lanes_n == 4'hf |=> !tgt_rvalid)
        else $error("answer with no byte enable");
    AST_UPPER: assert property (tgt_rvalid |-> tgt_rdata[31:16] == 16'h0000) else $error("upper half set");
    AST_DATA: assert property (take |=> tgt_rdata[15:0] == $past(pending_flags)) else $error("bad read data");
    AST_CLEAR: assert property (take && !under |=> !pending_flags[15]) else $error("flag kept after read");
    AST_UNDER: assert property (under |=> pending_flags[15]) else $error("underflow lost");
    AST_IRQ: assert property ($stable(interrupt_enable)
        |-> host_interrupt_oe == |(pending_flags & interrupt_enable)) else $error("interrupt level wrong");
    AST_LOW: assert property (host_interrupt_oe |-> !host_interrupt_out) else $error("pin not low");
    AST_FCS: assert property (rx_frame_end && !rx_fcs_ok |=> pending_flags[2]) else $error("fcs lost");
    AST_OVR: assert property (rx_fifo_write && rx_fifo_full |=> pending_flags[5]) else $error("overrun lost");
    cover property (take);
    cover property (take && under);
    cover property (host_interrupt_oe);
endmodule // event_status_props
bind master_event_status event_status_props u_props (.ref_clk(ref_clk), .rst(rst), .tgt_access(tgt_access),
    .tgt_read(tgt_read), .tgt_addr(tgt_addr), .byte_enable_lanes_n(byte_enable_lanes_n), .tgt_rdata(tgt_rdata),
    .tgt_rvalid(tgt_rvalid), .interrupt_enable(interrupt_enable), .host_interrupt_out(host_interrupt_out),
    .host_interrupt_oe(host_interrupt_oe), .pending_flags(pending_flags), .rx_frame_end(rx_frame_end),
    .rx_fcs_ok(rx_fcs_ok), .rx_fifo_write(rx_fifo_write), .rx_fifo_full(rx_fifo_full),
    .tx_fifo_read(tx_fifo_read), .tx_fifo_empty(tx_fifo_empty));
`default_nettype wire

// >>> bench/host_port.sv
// Purpose: Host side of the target port
// Assumes: Bench raises go just after a clock edge
// Notes:   Idle address lines move every cycle
`timescale 1ns/1ns
`default_nettype none
`include "event_status_regs.vh"
module host_port (
    // Request from the bench
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [3:0]  be_n,
    // Target port pins
    output logic             tgt_access,
    output logic             tgt_read,
    output logic [11:0]      tgt_addr,
    output logic [3:0]       byte_enable_lanes_n
);
    logic [11:0] idle_reg = 12'h000;
    // A held address would hide a design that ignores tgt_access
    always @(posedge ref_clk) idle_reg <= idle_reg + 12'h111;
    assign tgt_access = go;
    assign tgt_read = go ? !wr : idle_reg[0];
    assign tgt_addr = go ? `MASTER_EVENT_STATUS_OFFSET : idle_reg;
    assign byte_enable_lanes_n = go ? be_n : idle_reg[3:0];
endmodule // host_port
`default_nettype wire

// >>> bench/master_event_status_bench.sv
// Purpose: Self-checking bench for the master event status word
// Assumes: Counting thresholds set to two
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module master_event_status_bench;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        go = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  be_n = 4'h0;
    logic [15:0] ev = 16'h0000;
    logic [15:0] ien = 16'h0000;
    logic [15:0] cnt_bits = 16'h19c0;
    logic        zero_bit = 1'b0;
    logic        perr_pin = 1'b0;
    logic        crc32 = 1'b0;
    logic [15:0] len = 16'd33;
    wire         acc, is_rd, rv, irq_out, irq_oe;
    wire  [11:0] addr;
    wire  [3:0]  ben;
    wire  [31:0] rdata;
    wire  [15:0] pend;
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #25 ref_clk = ~ref_clk;
    host_port u_host (.ref_clk(ref_clk), .go(go), .wr(wr), .be_n(be_n), .tgt_access(acc), .tgt_read(is_rd),
        .tgt_addr(addr), .byte_enable_lanes_n(ben));
    master_event_status #(.COUNT_WIDTH(8)) u_dut (.ref_clk(ref_clk), .rst(rst), .tgt_access(acc),
        .tgt_read(is_rd), .tgt_addr(addr), .byte_enable_lanes_n(ben), .tgt_rdata(rdata), .tgt_rvalid(rv),
        .interrupt_enable(ien), .host_interrupt_out(irq_out), .host_interrupt_oe(irq_oe), .pending_flags(pend),
        .addr_parity_err(ev[0]), .special_cycle_parity_err(ev[0]), .master_abort_rcvd(ev[0]),
        .target_abort_det(ev[0]), .master_data_parity_err(ev[1]), .target_parity_err_pin(perr_pin),
        .rx_bit(ev[3]), .rx_bit_valid(ev[3] | zero_bit), .rx_frame_end(ev[2] | ev[4]), .rx_fcs_ok(!ev[2]),
        .rx_len_bits(ev[4] ? len : 16'd64), .rx_crc32(crc32), .max_len_bits(16'h0100),
        .rx_fifo_write(ev[5]), .rx_fifo_full(ev[5]), .queue_threshold({5{8'h02}}),
        .small_free_fetch(ev[6]), .large_free_fetch(ev[7]), .rx_ref_request(ev[9]),
        .small_free_empty(ev[9]), .large_free_empty(ev[9]), .ready_queue_write(ev[8] | ev[10]),
        .ready_queue_full(ev[10]), .tx_free_write(ev[11] | ev[13]), .tx_free_full(ev[13]),
        .tx_ready_fetch(ev[12]), .tx_packet_done(ev[14]), .completion_notify_flag(ev[14]),
        .tx_fifo_read(ev[15]), .tx_fifo_empty(ev[15]));
    task automatic end_sim();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Event held n cycles, then one idle cycle for the flag to land
    task automatic fire(input int i, input int n);
        ev[i] = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1 ev[i] = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    // Answer expected in the cycle after the taking edge
    task automatic rd(input logic [3:0] b, input logic w, input logic v, input logic [31:0] exp);
        go = 1'b1;
        be_n = b;
        wr = w;
        @(posedge ref_clk);
        #1 go = 1'b0;
        ev = 16'h0000;
        chk({31'h0, rv}, {31'h0, v});
        if (v) chk(rdata, exp);
        @(posedge ref_clk);
        #1;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'b0;
        rd(4'h0, 1'b0, 1'b1, 32'h0);
        for (int i = 0; i < 16; i++) begin
            fire(i, i == 3 ? 7 : 1);
            chk({31'h0, irq_oe}, 32'h0);
            if (cnt_bits[i]) begin
                rd(4'h0, 1'b0, 1'b1, 32'h0);
                fire(i, 1);
            end
            chk({16'h0, pend}, 32'h1 << i);
            rd(4'he, 1'b0, 1'b1, 32'h1 << i);
            rd(4'h0, 1'b0, 1'b1, 32'h0);
        end
        zero_bit = 1'b1;
        @(posedge ref_clk);
        #1 zero_bit = 1'b0;
        fire(3, 6);
        rd(4'h0, 1'b0, 1'b1, 32'h0);
        fire(3, 1);
        rd(4'h0, 1'b0, 1'b1, 32'h8);
        len = 16'd40;
        fire(4, 1);
        rd(4'h0, 1'b0, 1'b1, 32'h0);
        crc32 = 1'b1;
        fire(4, 1);
        rd(4'h0, 1'b0, 1'b1, 32'h10);
        len = 16'd264;
        fire(4, 1);
        rd(4'h0, 1'b0, 1'b1, 32'h10);
        perr_pin = 1'b1;
        @(posedge ref_clk);
        #1 perr_pin = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rd(4'h0, 1'b0, 1'b1, 32'h2);
        fire(0, 1);
        rd(4'hf, 1'b0, 1'b0, 32'h0);
        rd(4'h0, 1'b1, 1'b0, 32'h0);
        rd(4'h7, 1'b0, 1'b1, 32'h1);
        ien = 16'h8000;
        fire(15, 1);
        chk({31'h0, irq_oe}, 32'h1);
        chk({31'h0, irq_out}, 32'h0);
        ien = 16'h7fff;
        @(posedge ref_clk);
        #1 chk({31'h0, irq_oe}, 32'h0);
        rd(4'h0, 1'b0, 1'b1, 32'h8000);
        ev[15] = 1'b1;
        rd(4'h0, 1'b0, 1'b1, 32'h0);
        rd(4'h0, 1'b0, 1'b1, 32'h8000);
        end_sim();
    end
endmodule // master_event_status_bench
`default_nettype wire

// >>> src/abort_detect.v
// Purpose: Flags a run of seven or more ones on receive data
// Assumes: rx_bit qualified by rx_bit_valid, same clock
// Notes:   One pulse per run, however long the run lasts
`timescale 1ns/1ns
`default_nettype none
`include "event_status_regs.vh"

module abort_detect (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst,
    // Received bit stream
    input  wire rx_bit,
    input  wire rx_bit_valid,
    // Abort event
    output reg  abort_pulse
);

    reg [2:0] ones_reg;

    always @(posedge ref_clk) begin
        if (rst) begin
            ones_reg    <= 3'h0;
            abort_pulse <= 1'b0;
        end else begin
            abort_pulse <= 1'b0;
            if (rx_bit_valid) begin
                if (!rx_bit) begin
                    ones_reg <= 3'h0;
                end else if (ones_reg != 3'h7) begin
                    // Saturate so a long run fires once
                    ones_reg <= ones_reg + 3'h1;
                    if (ones_reg == (`ABORT_ONES_RUN - 1))
                        abort_pulse <= 1'b1;
                end
            end
        end
    end

endmodule // abort_detect

`default_nettype wire

// >>> src/event_status_regs.vh
// Purpose: Constants for the master event status block
// Assumes: Included by bare name; definitions only
// Notes:   Bit positions index the 16-bit flag vector
`ifndef EVENT_STATUS_REGS_VH
`define EVENT_STATUS_REGS_VH

// Register offset, byte address on the target port
`define MASTER_EVENT_STATUS_OFFSET 12'h008
`define MASTER_EVENT_STATUS_RESET  16'h0000
`define FLAG_COUNT                 16

// Flag positions
`define SYSTEM_ERROR_BIT            0
`define PARITY_ERROR_BIT            1
`define FRAME_CHECK_ERROR_BIT       2
`define RECEIVE_ABORT_BIT           3
`define PACKET_FORMAT_ERROR_BIT     4
`define RECEIVE_OVERRUN_BIT         5
`define SMALL_FREE_QUEUE_BIT        6
`define LARGE_FREE_QUEUE_BIT        7
`define RECEIVE_READY_QUEUE_BIT     8
`define RECEIVE_FREE_QUEUE_ERR_BIT  9
`define RECEIVE_READY_QUEUE_ERR_BIT 10
`define TRANSMIT_FREE_QUEUE_BIT     11
`define TRANSMIT_READY_QUEUE_BIT    12
`define TRANSMIT_FREE_QUEUE_ERR_BIT 13
`define TRANSMIT_COMPLETION_BIT     14
`define TRANSMIT_UNDERFLOW_BIT      15

// Receive framing figures, in bits
`define ABORT_ONES_RUN    7
`define MIN_LEN_CCITT     16'd32
`define MIN_LEN_CRC32     16'd48

`endif

// >>> src/level_sync.v
// Purpose: Two-flop synchroniser for a level from a pin
// Assumes: Input is asynchronous to ref_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module level_sync (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst,
    // Level in and out
    input  wire async_in,
    output reg  sync_out
);

    reg meta_reg;

    always @(posedge ref_clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // level_sync

`default_nettype wire

// >>> src/master_event_status.v
// Purpose: Master event status word, clear on read, host interrupt
// Assumes: Event inputs are one-cycle pulses on ref_clk, except
//          the target parity error pin, which is asynchronous
// Notes:   Enables come from the enable register outside this block
//          Read data answers in the cycle after the taking edge and holds until the next read
//          Writes to the word are ignored; only reads clear it
//          Upper half of the word always reads as zero
//          Counter thresholds of zero act as one
`timescale 1ns/1ns
`default_nettype none
`include "event_status_regs.vh"

module master_event_status #(
    parameter COUNT_WIDTH = 8
) (
    // Clock and reset
    input  wire                     ref_clk,
    input  wire                     rst,
    // Target register port
    input  wire                     tgt_access,
    input  wire                     tgt_read,
    input  wire [11:0]              tgt_addr,
    input  wire [3:0]               byte_enable_lanes_n,
    output reg  [31:0]              tgt_rdata,
    output reg                      tgt_rvalid,
    // Interrupt enables and host interrupt
    input  wire [15:0]              interrupt_enable,
    output reg                      host_interrupt_out,
    output reg                      host_interrupt_oe,
    output reg  [15:0]              pending_flags,
    // Bus error events
    input  wire                     addr_parity_err,
    input  wire                     special_cycle_parity_err,
    input  wire                     master_abort_rcvd,
    input  wire                     target_abort_det,
    input  wire                     master_data_parity_err,
    input  wire                     target_parity_err_pin,
    // Receive framing
    input  wire                     rx_bit,
    input  wire                     rx_bit_valid,
    input  wire                     rx_frame_end,
    input  wire                     rx_fcs_ok,
    input  wire [15:0]              rx_len_bits,
    input  wire                     rx_crc32,
    input  wire [15:0]              max_len_bits,
    input  wire                     rx_fifo_write,
    input  wire                     rx_fifo_full,
    // Descriptor queues
    input  wire [5*COUNT_WIDTH-1:0] queue_threshold,
    input  wire                     small_free_fetch,
    input  wire                     large_free_fetch,
    input  wire                     rx_ref_request,
    input  wire                     small_free_empty,
    input  wire                     large_free_empty,
    input  wire                     ready_queue_write,
    input  wire                     ready_queue_full,
    input  wire                     tx_free_write,
    input  wire                     tx_free_full,
    input  wire                     tx_ready_fetch,
    // Transmit side
    input  wire                     tx_packet_done,
    input  wire                     completion_notify_flag,
    input  wire                     tx_fifo_read,
    input  wire                     tx_fifo_empty
);

    localparam Q_SMALL    = 0;
    localparam Q_LARGE    = 1;
    localparam Q_RDY      = 2;
    localparam Q_TX_FREE  = 3;
    localparam Q_TX_READY = 4;

    reg  [15:0]            flags_reg;
    reg  [15:0]            flags_next;
    reg  [15:0]            set_vec;
    reg  [COUNT_WIDTH-1:0] queue_cnt_reg [0:4];
    reg  [COUNT_WIDTH-1:0] queue_cnt_next [0:4];
    reg  [4:0]             queue_event;
    reg  [4:0]             queue_hit;
    reg                    packet_bad;
    reg                    read_hit;
    wire                   target_parity_sync;
    wire                   abort_pulse;
    integer                q;
    integer                r;

    // Advance a count; report when the programmed number is reached
    function [COUNT_WIDTH:0] count_step;
        input [COUNT_WIDTH-1:0] cnt;
        input [COUNT_WIDTH-1:0] thr;
        reg   [COUNT_WIDTH-1:0] inc;
        begin
            inc = cnt + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            // A threshold of zero behaves as one
            if (inc >= thr)
                count_step = {1'b1, {COUNT_WIDTH{1'b0}}};
            else
                count_step = {1'b0, inc};
        end
    endfunction

    // Level of the host interrupt for a flag vector and its enables
    function any_enabled;
        input [15:0] flags;
        input [15:0] enables;
        begin
            any_enabled = |(flags & enables);
        end
    endfunction

    // Parity pin is asynchronous; two flops before any logic
    level_sync u_perr_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (target_parity_err_pin),
        .sync_out (target_parity_sync)
    );

    // Run counter sits on the raw bit stream, before framing
    abort_detect u_abort (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .rx_bit       (rx_bit),
        .rx_bit_valid (rx_bit_valid),
        .abort_pulse  (abort_pulse)
    );

    // Named views of the flag register
    wire                   system_error_flag = flags_reg[`SYSTEM_ERROR_BIT];
    wire                   parity_error_flag = flags_reg[`PARITY_ERROR_BIT];
    wire                   frame_check_error_flag = flags_reg[`FRAME_CHECK_ERROR_BIT];
    wire                   receive_abort_flag = flags_reg[`RECEIVE_ABORT_BIT];
    wire                   packet_format_error_flag = flags_reg[`PACKET_FORMAT_ERROR_BIT];
    wire                   receive_overrun_flag = flags_reg[`RECEIVE_OVERRUN_BIT];
    wire                   small_free_queue_flag = flags_reg[`SMALL_FREE_QUEUE_BIT];
    wire                   large_free_queue_flag = flags_reg[`LARGE_FREE_QUEUE_BIT];
    wire                   receive_ready_queue_flag = flags_reg[`RECEIVE_READY_QUEUE_BIT];
    wire                   receive_free_queue_error_flag = flags_reg[`RECEIVE_FREE_QUEUE_ERR_BIT];
    wire                   receive_ready_queue_error_flag = flags_reg[`RECEIVE_READY_QUEUE_ERR_BIT];
    wire                   transmit_free_queue_flag = flags_reg[`TRANSMIT_FREE_QUEUE_BIT];
    wire                   transmit_ready_queue_flag = flags_reg[`TRANSMIT_READY_QUEUE_BIT];
    wire                   transmit_free_queue_error_flag = flags_reg[`TRANSMIT_FREE_QUEUE_ERR_BIT];
    wire                   transmit_completion_flag = flags_reg[`TRANSMIT_COMPLETION_BIT];
    wire                   transmit_underflow_flag = flags_reg[`TRANSMIT_UNDERFLOW_BIT];

    // Word as the host sees it, bit 15 first
    wire [15:0]            status_word = {transmit_underflow_flag, transmit_completion_flag,
                                          transmit_free_queue_error_flag, transmit_ready_queue_flag,
                                          transmit_free_queue_flag, receive_ready_queue_error_flag,
                                          receive_free_queue_error_flag, receive_ready_queue_flag,
                                          large_free_queue_flag, small_free_queue_flag,
                                          receive_overrun_flag, packet_format_error_flag,
                                          receive_abort_flag, frame_check_error_flag,
                                          parity_error_flag, system_error_flag};

    // Shortest legal frame depends on the CRC in use
    wire [15:0]            min_len_bits = rx_crc32 ? `MIN_LEN_CRC32 : `MIN_LEN_CCITT;

    // Register decode
    always @* begin
        // Lane selection is not supported, only all-negated matters
        // Writes and other offsets fall through and clear nothing
        read_hit = tgt_access && tgt_read && (tgt_addr == `MASTER_EVENT_STATUS_OFFSET)
                   && (byte_enable_lanes_n != 4'hf);
    end

    // Packet format check at frame end
    always @* begin
        packet_bad = 1'b0;
        // Longer than the programmed maximum
        if (rx_len_bits > max_len_bits)
            packet_bad = 1'b1;
        // Below the shortest frame the CRC mode allows
        if (rx_len_bits < min_len_bits)
            packet_bad = 1'b1;
        // Not a whole number of octets
        if (rx_len_bits[2:0] != 3'h0)
            packet_bad = 1'b1;
    end

    // Descriptor queue notification counters
    always @* begin
        queue_event[Q_SMALL]    = small_free_fetch;
        queue_event[Q_LARGE]    = large_free_fetch;
        // Refused writes are errors, not progress, so they do not count
        queue_event[Q_RDY]      = ready_queue_write && !ready_queue_full;
        queue_event[Q_TX_FREE]  = tx_free_write && !tx_free_full;
        queue_event[Q_TX_READY] = tx_ready_fetch;
        queue_hit = 5'h00;
        for (q = 0; q < 5; q = q + 1) begin
            queue_cnt_next[q] = queue_cnt_reg[q];
            if (queue_event[q]) begin
                {queue_hit[q], queue_cnt_next[q]} =
                    count_step(queue_cnt_reg[q], queue_threshold[q*COUNT_WIDTH +: COUNT_WIDTH]);
            end
        end
    end

    always @(posedge ref_clk) begin
        // Own loop index; sharing q with the decode process races
        if (rst) begin
            for (r = 0; r < 5; r = r + 1)
                queue_cnt_reg[r] <= {COUNT_WIDTH{1'b0}};
        end else begin
            for (r = 0; r < 5; r = r + 1)
                queue_cnt_reg[r] <= queue_cnt_next[r];
        end
    end

    // Event sources; set regardless of any enable
    always @* begin
        set_vec = 16'h0000;
        // Bus errors
        set_vec[`SYSTEM_ERROR_BIT] = addr_parity_err || special_cycle_parity_err
                                     || master_abort_rcvd || target_abort_det;
        set_vec[`PARITY_ERROR_BIT] = master_data_parity_err || target_parity_sync;
        // Receive framing and FIFO
        set_vec[`FRAME_CHECK_ERROR_BIT] = rx_frame_end && !rx_fcs_ok;
        set_vec[`RECEIVE_ABORT_BIT] = abort_pulse;
        set_vec[`PACKET_FORMAT_ERROR_BIT] = rx_frame_end && packet_bad;
        set_vec[`RECEIVE_OVERRUN_BIT] = rx_fifo_write && rx_fifo_full;
        // Descriptor queues
        set_vec[`SMALL_FREE_QUEUE_BIT] = queue_hit[Q_SMALL];
        set_vec[`LARGE_FREE_QUEUE_BIT] = queue_hit[Q_LARGE];
        set_vec[`RECEIVE_READY_QUEUE_BIT] = queue_hit[Q_RDY];
        set_vec[`RECEIVE_FREE_QUEUE_ERR_BIT] = rx_ref_request && small_free_empty
                                               && large_free_empty;
        set_vec[`RECEIVE_READY_QUEUE_ERR_BIT] = ready_queue_write && ready_queue_full;
        set_vec[`TRANSMIT_FREE_QUEUE_BIT] = queue_hit[Q_TX_FREE];
        set_vec[`TRANSMIT_READY_QUEUE_BIT] = queue_hit[Q_TX_READY];
        set_vec[`TRANSMIT_FREE_QUEUE_ERR_BIT] = tx_free_write && tx_free_full;
        // Transmit side
        set_vec[`TRANSMIT_COMPLETION_BIT] = tx_packet_done && completion_notify_flag;
        set_vec[`TRANSMIT_UNDERFLOW_BIT] = tx_fifo_read && tx_fifo_empty;
    end

    // Clear on read; a set in the same cycle survives the clear
    always @* begin
        flags_next = (read_hit ? 16'h0000 : flags_reg) | set_vec;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            flags_reg <= `MASTER_EVENT_STATUS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Read answer one cycle after the request
    always @(posedge ref_clk) begin
        if (rst) begin
            tgt_rdata  <= 32'h0000_0000;
            tgt_rvalid <= 1'b0;
        end else begin
            tgt_rvalid <= read_hit;
            if (read_hit)
                // Upper half carries no flags and reads as zero
                tgt_rdata <= {16'h0000, status_word};
        end
    end

    // Open-drain host interrupt, low when driven
    always @(posedge ref_clk) begin
        if (rst) begin
            host_interrupt_out <= 1'b0;
            host_interrupt_oe  <= 1'b0;
            pending_flags      <= 16'h0000;
        end else begin
            host_interrupt_out <= 1'b0;
            // Follows flags_next so the pin moves with pending_flags
            host_interrupt_oe  <= any_enabled(flags_next, interrupt_enable);
            pending_flags      <= flags_next;
        end
    end

endmodule // master_event_status

`default_nettype wire
